// >>> common/imx_pkg.sv
// constants for the indexed move and register call execution block
package imx_pkg;
   localparam int          DATA_AW      = 12;
   localparam int          PC_W         = 21;
   localparam int          OFFSET_W     = 7;
   localparam logic [20:0] PC_STEP      = 21'h00_0002;
   localparam logic [15:0] OP_CALL_VIA_W = 16'h0014;
   localparam logic [8:0]  OP_MOVX_HI   = 9'h1D6;
   localparam logic [3:0]  OP_SECOND_HI = 4'hF;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [11:0] RESET_ADDR   = 12'h000;
   localparam logic [20:0] RESET_PC     = 21'h00_0000;
   localparam logic [1:0]  PHASE_LAST   = 2'h3;
   localparam logic [1:0]  PHASE_FIRST  = 2'h0;
   typedef enum logic [1:0] {IMX_IDLE, IMX_CALL2, IMX_MOV2} imx_state_t;
endpackage

// >>> logic/imx_exec.sv
// execution unit for register-indirect call and indexed memory move
`timescale 1ns/1ps
module imx_exec (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        phase_tick,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   input  wire logic [20:0] pc_current,
   input  wire logic [7:0]  working_register,
   input  wire logic [7:0]  pc_latch_high,
   input  wire logic [7:0]  pc_latch_upper,
   input  wire logic [11:0] index_pointer_two,
   input  wire logic [7:0]  mem_rdata,
   output logic [20:0]      stack_push_data,
   output logic             stack_push,
   output logic [20:0]      pc_load_value,
   output logic             pc_load,
   output logic [11:0]      mem_addr,
   output logic             mem_read,
   output logic [7:0]       mem_wdata,
   output logic             mem_write,
   output logic             flush_fetch,
   output logic             busy,
   output logic [1:0]       phase
);
   imx_pkg::imx_state_t state_q, state_d;
   logic [1:0]  phase_q;
   logic [11:0] dest_q;
   logic [7:0]  byte_q;
   logic [20:0] push_q, pcv_q;
   logic        push_v_q, pc_load_q, rd_q, wr_q, fl_q, busy_q;
   logic [11:0] addr_q;

   // cycle boundary: last phase of a four-phase instruction cycle
   wire cyc_end  = phase_tick && (phase_q == imx_pkg::PHASE_LAST);
   wire take     = cyc_end && instr_valid && (state_q == imx_pkg::IMX_IDLE);
   wire is_call  = (instr_word == imx_pkg::OP_CALL_VIA_W);
   wire is_move  = (instr_word[15:7] == imx_pkg::OP_MOVX_HI);
   // a stray second word matches neither opcode, so it falls through idle
   wire is_lone2 = (instr_word[15:12] == imx_pkg::OP_SECOND_HI);
   // 12-bit sum wraps, so every address stays inside the data space
   wire [11:0] src_addr = index_pointer_two
                        + {5'h00, instr_word[6:0]};
   wire [20:0] ret_addr = pc_current + imx_pkg::PC_STEP;
   wire [20:0] call_tgt = {pc_latch_upper[4:0], pc_latch_high,
                           working_register};

   always_comb begin
      state_d = state_q;
      if (cyc_end) begin
         case (state_q)
            imx_pkg::IMX_IDLE: begin
               if (take && is_call)
                  state_d = imx_pkg::IMX_CALL2;
               else if (take && is_move)
                  state_d = imx_pkg::IMX_MOV2;
            end
            imx_pkg::IMX_CALL2: state_d = imx_pkg::IMX_IDLE;
            imx_pkg::IMX_MOV2:  state_d = imx_pkg::IMX_IDLE;
            default:            state_d = imx_pkg::IMX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q  <= imx_pkg::IMX_IDLE;
         phase_q  <= imx_pkg::PHASE_FIRST;
         dest_q   <= imx_pkg::RESET_ADDR;
         byte_q   <= imx_pkg::RESET_BYTE;
      end else begin
         state_q <= state_d;
         if (phase_tick)
            phase_q <= phase_q + 2'h1;
         if (take && is_move)
            byte_q <= mem_rdata;
         // destination literal arrives as the next fetched word
         if (state_q == imx_pkg::IMX_MOV2 && phase_tick
             && phase_q == imx_pkg::PHASE_FIRST)
            dest_q <= instr_word[11:0];
      end
   end

   // outputs registered; working register, flags, bank select untouched
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         push_q   <= imx_pkg::RESET_PC;
         pcv_q    <= imx_pkg::RESET_PC;
         push_v_q  <= 1'b0;
         pc_load_q <= 1'b0;
         busy_q    <= 1'b0;
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         fl_q     <= 1'b0;
         addr_q   <= imx_pkg::RESET_ADDR;
      end else begin
         push_v_q  <= take && is_call;
         pc_load_q <= push_v_q;                   // pc after push
         // flop copy of the next state keeps busy glitch free
         busy_q    <= (state_d != imx_pkg::IMX_IDLE);
         fl_q     <= take && is_call;
         rd_q     <= take && is_move;
         wr_q     <= cyc_end && state_q == imx_pkg::IMX_MOV2;
         if (take && is_call) begin
            push_q <= ret_addr;
            pcv_q  <= call_tgt;
         end
         if (take && is_move)
            addr_q <= src_addr;
         else if (cyc_end && state_q == imx_pkg::IMX_MOV2)
            addr_q <= dest_q;
      end
   end

   assign stack_push_data = push_q;
   assign stack_push      = push_v_q;
   assign pc_load_value   = pcv_q;
   assign pc_load         = pc_load_q;
   assign mem_addr        = addr_q;
   assign mem_read        = rd_q;
   assign mem_wdata       = byte_q;
   assign mem_write       = wr_q;
   assign flush_fetch     = fl_q;
   assign busy            = busy_q;
   assign phase           = phase_q;

   // each check samples on the core clock and idles in reset
   chk_push_before_pc: assert property (
      @(posedge clk) disable iff (!reset_n)
      stack_push |=> pc_load)
      else $error("pc not loaded after push");

   chk_ret_value: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_call |=> stack_push_data == $past(ret_addr))
      else $error("return address wrong");

   chk_push_once: assert property (
      @(posedge clk) disable iff (!reset_n)
      stack_push |=> !stack_push)
      else $error("return address pushed twice");

   chk_low_from_w: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_call |=> pc_load_value[7:0] == $past(working_register))
      else $error("pc low not working reg");

   chk_high_latch: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_call |=> pc_load_value[15:8] == $past(pc_latch_high))
      else $error("pc high not latch");

   chk_upper_latch: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_call
      |=> pc_load_value[20:16] == $past(pc_latch_upper[4:0]))
      else $error("pc upper not latch");

   chk_call_two_cyc: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_call |=> busy)
      else $error("call not two cycles");

   // prefetched word is stale once the target changes
   chk_flush_on_call: assert property (
      @(posedge clk) disable iff (!reset_n)
      stack_push |-> flush_fetch)
      else $error("prefetch not flushed");

   chk_call_no_mem: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_q == imx_pkg::IMX_CALL2 |-> !mem_write && !mem_read)
      else $error("call touched memory");

   chk_src_addr: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_move |=> mem_read && mem_addr == $past(src_addr))
      else $error("move source addr wrong");

   chk_dest_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      mem_write |-> mem_addr == dest_q)
      else $error("move dest wrong");

   chk_write_byte: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_move |=> mem_wdata == $past(mem_rdata))
      else $error("move byte not source byte");

   chk_move_two_cyc: assert property (
      @(posedge clk) disable iff (!reset_n)
      mem_read |-> ##[1:8] mem_write)
      else $error("move no write");

   chk_write_ends: assert property (
      @(posedge clk) disable iff (!reset_n)
      mem_write |-> !busy)
      else $error("move write not in last cycle");

   chk_move_no_stack: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_move |=> !stack_push && !flush_fetch)
      else $error("move touched stack");

   chk_lone_nop: assert property (
      @(posedge clk) disable iff (!reset_n)
      take && is_lone2 |=> !busy && !stack_push && !mem_read)
      else $error("lone second word acted");

   cov_call: cover property (@(posedge clk) disable iff (!reset_n)
      take && is_call);
   cov_pc_load: cover property (@(posedge clk) disable iff (!reset_n)
      pc_load);
   cov_move_read: cover property (@(posedge clk) disable iff (!reset_n)
      mem_read);
   cov_move: cover property (@(posedge clk) disable iff (!reset_n)
      mem_write);
   cov_lone: cover property (@(posedge clk) disable iff (!reset_n)
      take && is_lone2);
endmodule

// >>> tb/imx_mem_model.sv
// data memory model for the move unit, read combinational
`timescale 1ns/1ps
module imx_mem_model (
   input  wire logic        clk,
   input  wire logic [11:0] rd_addr,
   output logic [7:0]       rd_data,
   input  wire logic [11:0] wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_en
);
   logic [7:0] mem [4096];
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 5);
   assign rd_data = mem[rd_addr];
   always @(posedge clk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule

// >>> tb/indexed_move_and_reg_call_exec_test.sv
// self-checking bench for the call and indexed move unit
`timescale 1ns/1ps
module indexed_move_and_reg_call_exec_test;
   logic        clk, reset_n, phase_tick, instr_valid, busy, flush_fetch;
   logic        stack_push, pc_load, mem_read, mem_write;
   logic [15:0] instr_word;
   logic [20:0] pc_current, stack_push_data, pc_load_value;
   logic [7:0]  working_register, pc_latch_high, pc_latch_upper;
   logic [7:0]  mem_rdata, mem_wdata;
   logic [11:0] index_pointer_two, mem_addr, src, dest, src_exp;
   logic [6:0]  off;
   logic [1:0]  phase;
   int          n_errors = 0, total_checks = 0, seed = 32'hcdbb;
   logic [7:0]  exp_mem [4096];
   assign src = index_pointer_two + {5'h00, instr_word[6:0]};
   // every strobe and level that must stay quiet when nothing runs
   wire  [5:0]  acts = {stack_push, pc_load, mem_read, mem_write,
                        flush_fetch, busy};
   imx_exec imx_exec_i (.clk(clk), .reset_n(reset_n),
      .phase_tick(phase_tick), .instr_word(instr_word),
      .instr_valid(instr_valid), .pc_current(pc_current),
      .working_register(working_register),
      .pc_latch_high(pc_latch_high), .pc_latch_upper(pc_latch_upper),
      .index_pointer_two(index_pointer_two), .mem_rdata(mem_rdata),
      .stack_push_data(stack_push_data), .stack_push(stack_push),
      .pc_load_value(pc_load_value), .pc_load(pc_load),
      .mem_addr(mem_addr), .mem_read(mem_read), .mem_wdata(mem_wdata),
      .mem_write(mem_write), .flush_fetch(flush_fetch), .busy(busy),
      .phase(phase));
   imx_mem_model imx_mem_model_i (.clk(clk), .rd_addr(src),
      .rd_data(mem_rdata), .wr_addr(mem_addr), .wr_data(mem_wdata),
      .wr_en(mem_write));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [20:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic issue(input logic [15:0] w1, w2);
      @(negedge clk);
      while (phase !== 2'h3 || busy !== 1'b0) @(negedge clk);
      instr_word = w1;
      instr_valid = 1;
      @(negedge clk);
      instr_valid = 0;
      instr_word = w2;
   endtask
   task automatic wait_hi(ref logic s);
      int k;
      for (k = 0; k < 24 && s !== 1'b1; k++) @(negedge clk);
      check(k < 24, 1, "strobe missing");
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   initial begin
      reset_n = 0; phase_tick = 1; instr_valid = 0; instr_word = 16'h0000;
      pc_current = 0; working_register = 0; pc_latch_high = 0;
      pc_latch_upper = 0; index_pointer_two = 0;
      for (int i = 0; i < 4096; i++) exp_mem[i] = 8'(i * 37 + 5);
      repeat (2) @(negedge clk);
      check({acts, phase}, 0, "reset quiet");
      reset_n = 1;
      for (int i = 0; i < 6; i++) begin
         pc_current = 21'($random(seed));
         {pc_latch_upper, pc_latch_high, working_register} =
            24'($random(seed));
         issue(imx_pkg::OP_CALL_VIA_W, 16'h0000);
         wait_hi(stack_push);
         check(stack_push_data, pc_current + imx_pkg::PC_STEP, "ret");
         check({flush_fetch, busy}, 2'h3, "call busy");
         @(negedge clk);
         check(pc_load, 1, "pc load");
         check(pc_load_value, {pc_latch_upper[4:0], pc_latch_high,
            working_register}, "target");
         // top corner of the space first, then random addresses
         index_pointer_two = (i == 0) ? 12'hF80 : 12'($random(seed));
         off = (i == 0) ? 7'h7F : 7'($random(seed));
         dest = (i == 0) ? 12'h000 : 12'($random(seed));
         // top sixteen bytes stand in for the core's pc and stack registers
         if (dest[11:4] == 8'hFF)
            dest[4] = 1'b0;
         src_exp = 12'(index_pointer_two + off);
         issue({imx_pkg::OP_MOVX_HI, off}, {imx_pkg::OP_SECOND_HI, dest});
         wait_hi(mem_read);
         check(mem_addr, src_exp, "src");
         wait_hi(mem_write);
         check(mem_addr, dest, "dest");
         check(mem_wdata, exp_mem[src_exp], "byte");
         exp_mem[dest] = exp_mem[src_exp];
         issue({imx_pkg::OP_SECOND_HI, 12'($random(seed))}, 16'h0000);
         repeat (8) begin
            @(negedge clk);
            check(acts, 0, "nop");
         end
         $display("test round %0d done", i);
      end
      // reset in mid-call, then a fresh call must still work
      issue(imx_pkg::OP_CALL_VIA_W, 16'h0000);
      reset_n = 0;
      repeat (2) @(negedge clk);
      check({acts, phase}, 0, "mid reset");
      reset_n = 1;
      pc_current = 21'($random(seed));
      issue(imx_pkg::OP_CALL_VIA_W, 16'h0000);
      wait_hi(stack_push);
      check(stack_push_data, pc_current + imx_pkg::PC_STEP, "ret");
      $display("reset test done");
      summarize();
   end
endmodule
